// >>> mid_dec_if.sv
// Carries decoded fields between the field decoder and the execute stage.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface mid_dec_if;
	import mid_pkg::*;
	logic [13:0] insn;
	mid_op_t     op;
	logic [6:0]  fAddr;
	logic        dest;
	logic [2:0]  bitSel;
	logic [7:0]  lit;
	logic [10:0] target;
	modport dec (input insn, output op, fAddr, dest, bitSel, lit, target);
	modport exe (output insn, input op, fAddr, dest, bitSel, lit, target);
endinterface : mid_dec_if
`default_nettype wire

// >>> mid_decode_top.sv
// Decode and execute stage of the 14-bit instruction core.
// Assumes insnValid words from program memory; file data read combinationally.
`timescale 1ns/1ns
`default_nettype none
module mid_decode_top
	import mid_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Instruction in
	input  wire logic        insnValid,
	input  wire logic [13:0] insnWord,
	// File register read data
	input  wire logic [7:0]  fileRdData,
	input  wire logic [7:0]  portPins,
	// Timer0 prescaler assignment (1 = watchdog)
	input  wire logic        prescToWdog,
	// File write
	output logic             fileWrEn_ff,
	output logic [6:0]       fileAddr_ff,
	output logic [7:0]       fileWrData_ff,
	// Core state
	output logic [7:0]       wreg_ff,
	output logic             carry_ff,
	output logic             halfByteCarry_ff,
	output logic             zero_ff,
	output logic             watchdogExpiryFlag_ff,
	output logic             standbyEnteredFlag_ff,
	// Control outputs
	output logic             pcLoad_ff,
	output logic [10:0]      pcTarget_ff,
	output logic             stackPush_ff,
	output logic             stackPop_ff,
	output logic             idleCycle_ff,
	output logic             standbyReq_ff,
	output logic             watchdogClear_ff,
	output logic             prescClear_ff
);
	mid_dec_if d ();
	mid_state_t state_ff;
	logic [7:0] src, res;
	logic [8:0] sum;
	logic [4:0] hsum;
	logic selBit, skip, toFile, toW, setZ, setC, setDC, pcMod, busy;
	logic [7:0] pinMeta_ff, pinSync_ff;

	assign d.insn = insnWord;
	mid_field_dec u_dec (.d(d));

	// Two-flop pin synchroniser
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			{pinSync_ff, pinMeta_ff} <= 16'h0000;
		else
			{pinSync_ff, pinMeta_ff} <= {pinMeta_ff, portPins};
	end

	// Port registers read from the pins
	assign src = (d.fAddr >= ADDR_PORT_LO && d.fAddr <= ADDR_PORT_HI) ? pinSync_ff : fileRdData;
	assign selBit = src[d.bitSel];
	assign busy = (state_ff != ST_EXEC);

	// ****************************************
	// Arithmetic and result select
	// ****************************************
	always_comb
	begin
		res = 8'h00;
		sum = 9'h000;
		hsum = 5'h00;
		skip = 1'b0;
		toFile = 1'b0;
		toW = 1'b0;
		setZ = 1'b0;
		setC = 1'b0;
		setDC = 1'b0;
		pcMod = 1'b0;
		case (d.op)
			OP_OR, OP_AND, OP_XOR, OP_MOVF, OP_COM, OP_DEC, OP_INC, OP_SWAP,
			OP_RL, OP_RR, OP_DECSZ, OP_INCSZ, OP_ADD, OP_SUB:
			begin
				toFile = d.dest;
				toW = !d.dest;
				setZ = 1'b1;
				case (d.op)
					OP_OR: res = wreg_ff | src;
					OP_AND: res = wreg_ff & src;
					OP_XOR: res = wreg_ff ^ src;
					OP_MOVF: res = src;
					OP_COM: res = ~src;
					OP_SWAP:
					begin
						res = {src[3:0], src[7:4]};
						setZ = 1'b0;
					end
					OP_RL:
					begin
						res = {src[6:0], carry_ff};
						sum = {src[7], 8'h00};
						setZ = 1'b0;
						setC = 1'b1;
					end
					OP_RR:
					begin
						res = {carry_ff, src[7:1]};
						sum = {src[0], 8'h00};
						setZ = 1'b0;
						setC = 1'b1;
					end
					OP_ADD:
					begin
						sum = {1'b0, src} + {1'b0, wreg_ff};
						hsum = {1'b0, src[3:0]} + {1'b0, wreg_ff[3:0]};
						res = sum[7:0];
						setC = 1'b1;
						setDC = 1'b1;
					end
					OP_SUB:
					begin
						sum = {1'b0, src} + {1'b0, ~wreg_ff} + 9'h001;
						hsum = {1'b0, src[3:0]} + {1'b0, ~wreg_ff[3:0]} + 5'h01;
						res = sum[7:0];
						setC = 1'b1;
						setDC = 1'b1;
					end
					OP_DEC, OP_DECSZ: res = src - 8'h01;
					default: res = src + 8'h01;
				endcase
				if (d.op == OP_DECSZ || d.op == OP_INCSZ)
				begin
					setZ = 1'b0;
					skip = (res == 8'h00);
				end
			end
			OP_CLR:
			begin
				toFile = d.dest;
				toW = !d.dest;
				setZ = 1'b1;
			end
			OP_MOVWF:
			begin
				res = wreg_ff;
				toFile = 1'b1;
			end
			OP_BCF, OP_BSF:
			begin
				res = src;
				res[d.bitSel] = (d.op == OP_BSF);
				toFile = 1'b1;
			end
			OP_BTSC: skip = !selBit;
			OP_BTSS: skip = selBit;
			OP_MOVLW, OP_RETURN_LOADING_LITERAL:
			begin
				res = d.lit;
				toW = 1'b1;
				pcMod = (d.op == OP_RETURN_LOADING_LITERAL);
			end
			OP_ORLW, OP_ANDLW, OP_XOR_LITERAL_INTO_WREG:
			begin
				res = (d.op == OP_ORLW) ? (wreg_ff | d.lit) :
					(d.op == OP_XOR_LITERAL_INTO_WREG) ? (wreg_ff ^ d.lit) : (wreg_ff & d.lit);
				toW = 1'b1;
				setZ = 1'b1;
			end
			OP_SUBTRACT_FROM_LITERAL, OP_ADDLW:
			begin
				sum = (d.op == OP_SUBTRACT_FROM_LITERAL) ? ({1'b0, d.lit} + {1'b0, ~wreg_ff} + 9'h001)
					: ({1'b0, d.lit} + {1'b0, wreg_ff});
				hsum = (d.op == OP_SUBTRACT_FROM_LITERAL) ? ({1'b0, d.lit[3:0]} + {1'b0, ~wreg_ff[3:0]} + 5'h01)
					: ({1'b0, d.lit[3:0]} + {1'b0, wreg_ff[3:0]});
				res = sum[7:0];
				toW = 1'b1;
				setZ = 1'b1;
				setC = 1'b1;
				setDC = 1'b1;
			end
			OP_CALL, OP_GOTO, OP_RETURN, OP_RETFIE: pcMod = 1'b1;
			default: res = 8'h00;
		endcase
	end

	// ****************************************
	// Cycle state: taken skip or PC change adds an idle cycle
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state_ff <= ST_EXEC;
		else
		begin
			case (state_ff)
				ST_EXEC: if (insnValid && (skip || pcMod)) state_ff <= ST_IDLE;
				ST_IDLE: state_ff <= ST_EXEC;
				default: state_ff <= ST_EXEC;
			endcase
		end
	end

	// ****************************************
	// File write and working register
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			fileWrEn_ff <= 1'b0;
			fileAddr_ff <= 7'h00;
			fileWrData_ff <= 8'h00;
			wreg_ff <= 8'h00;
		end
		else
		begin
			fileWrEn_ff <= insnValid && !busy && toFile;
			fileAddr_ff <= d.fAddr;
			fileWrData_ff <= res;
			if (insnValid && !busy && toW)
				wreg_ff <= res;
		end
	end

	// ****************************************
	// Arithmetic flags
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			carry_ff <= 1'b0;
			halfByteCarry_ff <= 1'b0;
			zero_ff <= 1'b0;
		end
		else if (insnValid && !busy)
		begin
			if (setZ)
				zero_ff <= (res == 8'h00);
			if (setC)
				carry_ff <= sum[8];
			if (setDC)
				halfByteCarry_ff <= hsum[4];
		end
	end

	// ****************************************
	// Watchdog, standby and prescaler side effects
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			watchdogExpiryFlag_ff <= 1'b1;
			standbyEnteredFlag_ff <= 1'b1;
			standbyReq_ff <= 1'b0;
			watchdogClear_ff <= 1'b0;
			prescClear_ff <= 1'b0;
		end
		else
		begin
			standbyReq_ff <= insnValid && !busy && d.op == OP_SLEEP;
			watchdogClear_ff <= insnValid && !busy && (d.op == OP_SLEEP || d.op == OP_CLEAR_WATCHDOG);
			prescClear_ff <= insnValid && !busy && (((d.op == OP_SLEEP || d.op == OP_CLEAR_WATCHDOG) && prescToWdog)
				|| (toFile && d.fAddr == ADDR_TIMER0_COUNT && !prescToWdog));
			if (insnValid && !busy && d.op == OP_CLEAR_WATCHDOG)
			begin
				watchdogExpiryFlag_ff <= 1'b1;
				standbyEnteredFlag_ff <= 1'b1;
			end
			else if (insnValid && !busy && d.op == OP_SLEEP)
			begin
				watchdogExpiryFlag_ff <= 1'b1;
				standbyEnteredFlag_ff <= 1'b0;
			end
		end
	end

	// ****************************************
	// Program counter and idle marker
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pcLoad_ff <= 1'b0;
			pcTarget_ff <= 11'h000;
			stackPush_ff <= 1'b0;
			stackPop_ff <= 1'b0;
			idleCycle_ff <= 1'b0;
		end
		else
		begin
			pcLoad_ff <= insnValid && !busy && (d.op == OP_CALL || d.op == OP_GOTO);
			pcTarget_ff <= d.target;
			stackPush_ff <= insnValid && !busy && d.op == OP_CALL;
			stackPop_ff <= insnValid && !busy && (d.op == OP_RETURN || d.op == OP_RETFIE || d.op == OP_RETURN_LOADING_LITERAL);
			idleCycle_ff <= busy;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_skip_idle: assert property (@(posedge clk) disable iff (!rstn)
		(insnValid && !busy && skip) |=> (state_ff == ST_IDLE) ##1 idleCycle_ff)
		else $error("taken skip did not idle");
	a_return_loading_literal_two: assert property (@(posedge clk) disable iff (!rstn)
		(insnValid && !busy && d.op == OP_RETURN_LOADING_LITERAL) |=> stackPop_ff && wreg_ff == $past(d.lit) ##1 idleCycle_ff)
		else $error("return with literal wrong");
	a_or_zero: assert property (@(posedge clk) disable iff (!rstn)
		(insnValid && !busy && d.op == OP_ORLW) |=> zero_ff == (wreg_ff == 8'h00) && $stable(carry_ff))
		else $error("literal OR flags wrong");
	a_rl_carry: assert property (@(posedge clk) disable iff (!rstn)
		(insnValid && !busy && d.op == OP_RL) |=> carry_ff == $past(src[7]) && $stable(zero_ff))
		else $error("rotate left carry wrong");
	a_decsz_flags: assert property (@(posedge clk) disable iff (!rstn)
		(insnValid && !busy && d.op == OP_DECSZ) |=> $stable(zero_ff) && $stable(carry_ff))
		else $error("decrement skip touched flags");
	a_sleep_flags: assert property (@(posedge clk) disable iff (!rstn)
		(insnValid && !busy && d.op == OP_SLEEP) |=> !standbyEnteredFlag_ff && watchdogExpiryFlag_ff && watchdogClear_ff)
		else $error("standby flags wrong");
	a_clear_watchdog_presc: assert property (@(posedge clk) disable iff (!rstn)
		(insnValid && !busy && d.op == OP_CLEAR_WATCHDOG && prescToWdog) |=> prescClear_ff && watchdogClear_ff)
		else $error("prescaler not cleared");
	a_dest_route: assert property (@(posedge clk) disable iff (!rstn)
		(insnValid && !busy && d.op == OP_XOR && !d.dest) |=> !fileWrEn_ff)
		else $error("destination zero wrote file");
	c_skip: cover property (@(posedge clk) disable iff (!rstn) insnValid && !busy && skip);
	c_call: cover property (@(posedge clk) disable iff (!rstn) insnValid && !busy && d.op == OP_CALL);
	c_sleep: cover property (@(posedge clk) disable iff (!rstn) standbyReq_ff);
endmodule : mid_decode_top
`default_nettype wire

// >>> mid_field_dec.sv
// Combinational field decoder for 14-bit instruction words.
// Assumes the word is stable for the cycle it is decoded in.
`timescale 1ns/1ns
`default_nettype none
module mid_field_dec
	import mid_pkg::*;
(
	// Decoded word
	mid_dec_if.dec d
);
	logic [13:0] w;
	assign w = d.insn;
	assign d.fAddr = w[FADDR_W-1:0];
	assign d.dest = w[DEST_BIT];
	assign d.bitSel = w[BIT_LSB+2:BIT_LSB];
	assign d.lit = w[DATA_W-1:0];
	assign d.target = w[CALL_W-1:0];

	// ****************************************
	// Opcode pattern match
	// ****************************************
	always_comb
	begin
		d.op = OP_BAD;
		case (w[13:12])
			2'b00:
			begin
				case (w[11:8])
					4'h0:
					begin
						if (w[7])
							d.op = OP_MOVWF;
						else if (w == WORD_CLRWDOG)
							d.op = OP_CLEAR_WATCHDOG;
						else if (w == WORD_STANDBY)
							d.op = OP_SLEEP;
						else if (w == WORD_RETURN)
							d.op = OP_RETURN;
						else if (w == WORD_RETINT)
							d.op = OP_RETFIE;
						else if (w[4:0] == 5'h00)
							d.op = OP_NOP;
					end
					4'h1: d.op = OP_CLR;
					4'h2: d.op = OP_SUB;
					4'h3: d.op = OP_DEC;
					4'h4: d.op = OP_OR;
					4'h5: d.op = OP_AND;
					4'h6: d.op = OP_XOR;
					4'h7: d.op = OP_ADD;
					4'h8: d.op = OP_MOVF;
					4'h9: d.op = OP_COM;
					4'hA: d.op = OP_INC;
					4'hB: d.op = OP_DECSZ;
					4'hC: d.op = OP_RR;
					4'hD: d.op = OP_RL;
					4'hE: d.op = OP_SWAP;
					default: d.op = OP_INCSZ;
				endcase
			end
			2'b01:
			begin
				case (w[11:10])
					2'b00: d.op = OP_BCF;
					2'b01: d.op = OP_BSF;
					2'b10: d.op = OP_BTSC;
					default: d.op = OP_BTSS;
				endcase
			end
			2'b10: d.op = w[11] ? OP_GOTO : OP_CALL;
			default:
			begin
				casez (w[11:8])
					4'b00??: d.op = OP_MOVLW;
					4'b01??: d.op = OP_RETURN_LOADING_LITERAL;
					4'b1000: d.op = OP_ORLW;
					4'b1001: d.op = OP_ANDLW;
					4'b1010: d.op = OP_XOR_LITERAL_INTO_WREG;
					4'b110?: d.op = OP_SUBTRACT_FROM_LITERAL;
					4'b111?: d.op = OP_ADDLW;
					default: d.op = OP_BAD;
				endcase
			end
		endcase
	end
endmodule : mid_field_dec
`default_nettype wire

// >>> mid_file_model.sv
// Data-file partner model for the decoder testbench.
// Assumes one clock; read is combinational from the presented word's address.
`timescale 1ns/1ns
`default_nettype none
module mid_file_model
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Read side
	input  wire logic       rdSel,
	input  wire logic [6:0] rdAddr,
	output logic      [7:0] rdData,
	// Write side
	input  wire logic       wrEn,
	input  wire logic [6:0] wrAddr,
	input  wire logic [7:0] wrData
);
	logic [7:0] mem [128];

	// ****************************************
	// Read, garbage when no word is presented
	// ****************************************
	// Write-through so a word right after a write sees the new value
	assign rdData = rdSel ? ((wrEn && wrAddr == rdAddr) ? wrData : mem[rdAddr]) : ~mem[rdAddr];

	// ****************************************
	// Write
	// ****************************************
	always @(posedge clk)
	begin
		if (rstn && wrEn)
		begin
			mem[wrAddr] <= wrData;
		end
	end
endmodule : mid_file_model
`default_nettype wire

// >>> mid_pkg.sv
// Constants, opcode patterns and control enums for the 14-bit instruction decoder.
// Assumes a single clock domain; no register bus.
package mid_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int INSN_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int DEST_BIT = 7;
	localparam int BIT_LSB = 7;
	localparam int CALL_W = 11;

	// ****************************************
	// Fixed words
	// ****************************************
	localparam logic [13:0] WORD_STANDBY = 14'h0063;
	localparam logic [13:0] WORD_CLRWDOG = 14'h0064;
	localparam logic [13:0] WORD_RETURN = 14'h0008;
	localparam logic [13:0] WORD_RETINT = 14'h0009;

	// ****************************************
	// Port and timer0 file addresses (bank-low view)
	// ****************************************
	localparam logic [6:0] ADDR_TIMER0_COUNT = 7'h01;
	localparam logic [6:0] ADDR_PORT_LO = 7'h05;
	localparam logic [6:0] ADDR_PORT_HI = 7'h09;

	// ****************************************
	// Operation codes
	// ****************************************
	typedef enum logic [5:0] {
		OP_NOP, OP_MOVWF, OP_CLR, OP_SUB, OP_DEC, OP_OR, OP_AND, OP_XOR,
		OP_ADD, OP_MOVF, OP_COM, OP_INC, OP_DECSZ, OP_RR, OP_RL, OP_SWAP,
		OP_INCSZ, OP_BCF, OP_BSF, OP_BTSC, OP_BTSS, OP_CALL, OP_GOTO,
		OP_MOVLW, OP_RETURN_LOADING_LITERAL, OP_ORLW, OP_ANDLW, OP_XOR_LITERAL_INTO_WREG, OP_SUBTRACT_FROM_LITERAL, OP_ADDLW,
		OP_RETURN, OP_RETFIE, OP_CLEAR_WATCHDOG, OP_SLEEP, OP_BAD
	} mid_op_t;

	// ****************************************
	// Execution state
	// ****************************************
	typedef enum logic [1:0] {
		ST_EXEC = 2'b01,
		ST_IDLE = 2'b10
	} mid_state_t;

endpackage : mid_pkg

// >>> tb_midrange_14bit_instruction_decode.sv
// Self-checking testbench for the decode and execute stage.
// Assumes mid_pkg, the decode interface and the file model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("unexpected at %0t got %h expected %h", $time, g, e); end end
module tb_midrange_14bit_instruction_decode
	import mid_pkg::*;
;
	typedef struct {logic [46:0] v; bit two; int due;} mid_note_t;
	logic clk, rstn, insnValid, prescToWdog;
	logic [13:0] insnWord;
	logic [7:0] portPins, wreg_ff, fileWrData_ff, fileRdData;
	logic [6:0] fileAddr_ff;
	logic [10:0] pcTarget_ff;
	logic fileWrEn_ff, carry_ff, halfByteCarry_ff, zero_ff, watchdogExpiryFlag_ff, standbyEnteredFlag_ff;
	logic pcLoad_ff, stackPush_ff, stackPop_ff, idleCycle_ff, standbyReq_ff, watchdogClear_ff, prescClear_ff;
	int errors, total_checks, cyc;
	mid_note_t expQ[$];
	logic [7:0] wr, fmem [128];
	logic cf, hf, zf, toF, pdF;
	logic [15:0] pinHist;
	logic [13:0] tmpl [24] = '{14'h0400, 14'h0600, 14'h0D00, 14'h0C00, 14'h0B00, 14'h0F00, 14'h1800, 14'h1C00,
		14'h3800, 14'h3A00, 14'h3C00, 14'h3400, 14'h3000, 14'h2000, 14'h2800, 14'h0064, 14'h0063,
		14'h3900, 14'h3E00, 14'h0008, 14'h0009, 14'h0700, 14'h0200, 14'h0500};
	logic [13:0] msk [24] = '{14'h008F, 14'h008F, 14'h008F, 14'h008F, 14'h008F, 14'h008F, 14'h038F, 14'h038F,
		14'h00FF, 14'h00FF, 14'h01FF, 14'h03FF, 14'h03FF, 14'h07FF, 14'h07FF, 14'h0000, 14'h0000,
		14'h00FF, 14'h01FF, 14'h0000, 14'h0000, 14'h008F, 14'h008F, 14'h008F};

	mid_decode_top u_dut (.clk(clk), .rstn(rstn), .insnValid(insnValid), .insnWord(insnWord),
		.fileRdData(fileRdData), .portPins(portPins), .prescToWdog(prescToWdog), .fileWrEn_ff(fileWrEn_ff),
		.fileAddr_ff(fileAddr_ff), .fileWrData_ff(fileWrData_ff), .wreg_ff(wreg_ff), .carry_ff(carry_ff),
		.halfByteCarry_ff(halfByteCarry_ff), .zero_ff(zero_ff), .watchdogExpiryFlag_ff(watchdogExpiryFlag_ff),
		.standbyEnteredFlag_ff(standbyEnteredFlag_ff), .pcLoad_ff(pcLoad_ff), .pcTarget_ff(pcTarget_ff),
		.stackPush_ff(stackPush_ff), .stackPop_ff(stackPop_ff), .idleCycle_ff(idleCycle_ff),
		.standbyReq_ff(standbyReq_ff), .watchdogClear_ff(watchdogClear_ff), .prescClear_ff(prescClear_ff));

	mid_file_model u_file (.clk(clk), .rstn(rstn), .rdSel(insnValid), .rdAddr(insnWord[6:0]),
		.rdData(fileRdData), .wrEn(fileWrEn_ff), .wrAddr(fileAddr_ff), .wrData(fileWrData_ff));

	// ****************************************
	// Clock and cycle count
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) cyc++;

	// Pin values as seen after the two-flop synchroniser
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pinHist <= 16'h0000;
		else
			pinHist <= {pinHist[7:0], portPins};
	end

	task automatic print_verdict;
		if (errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	task automatic do_reset;
		@(negedge clk);
		rstn = 1'b0;
		insnValid = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		{wr, cf, hf, zf, toF, pdF} = {8'h00, 3'b000, 2'b11};
		`CHK({wreg_ff, carry_ff, halfByteCarry_ff, zero_ff, watchdogExpiryFlag_ff, standbyEnteredFlag_ff, fileWrEn_ff}, 14'h0006)
	endtask : do_reset

	// ****************************************
	// Reference behaviour of one word
	// ****************************************
	task automatic issue(input logic [13:0] w);
		logic [7:0] src, res;
		logic [8:0] s9;
		logic [10:0] tgt;
		logic wrF, byteOp, pop, push, pcl, wclr, pclr, sreq;
		bit two;
		int k;
		{wrF, byteOp, pop, push, pcl, wclr, pclr, sreq, two, tgt, res} = '0;
		@(negedge clk);
		insnValid = 1'b1;
		insnWord = w;
		portPins = 8'($urandom);
		prescToWdog = 1'($urandom);
		src = (w[6:0] >= ADDR_PORT_LO && w[6:0] <= ADDR_PORT_HI) ? pinHist[15:8] : fmem[w[6:0]];
		casez (w)
			14'b00_0100_????????: begin res = wr | src; zf = (res == 8'h00); byteOp = 1; end
			14'b00_0110_????????: begin res = wr ^ src; zf = (res == 8'h00); byteOp = 1; end
			14'b00_1101_????????: begin res = {src[6:0], cf}; cf = src[7]; byteOp = 1; end
			14'b00_1100_????????: begin res = {cf, src[7:1]}; cf = src[0]; byteOp = 1; end
			14'b00_1011_????????: begin res = src - 8'h01; two = (res == 8'h00); byteOp = 1; end
			14'b00_1111_????????: begin res = src + 8'h01; two = (res == 8'h00); byteOp = 1; end
			14'b01_10??_????????: two = !src[w[9:7]];
			14'b01_11??_????????: two = src[w[9:7]];
			14'b11_1000_????????: begin wr = wr | w[7:0]; zf = (wr == 8'h00); end
			14'b11_1010_????????: begin wr = wr ^ w[7:0]; zf = (wr == 8'h00); end
			14'b11_110?_????????:
			begin
				s9 = {1'b0, w[7:0]} + {1'b0, ~wr} + 9'h001;
				hf = ({1'b0, w[3:0]} + {1'b0, ~wr[3:0]} + 5'h01) > 5'h0F;
				{cf, wr} = s9;
				zf = (wr == 8'h00);
			end
			14'b11_01??_????????: begin wr = w[7:0]; pop = 1; two = 1; end
			14'b11_00??_????????: wr = w[7:0];
			14'b10_0???_????????: begin push = 1; pcl = 1; tgt = w[10:0]; two = 1; end
			14'b10_1???_????????: begin pcl = 1; tgt = w[10:0]; two = 1; end
			14'b00_0101_????????: begin res = wr & src; zf = (res == 8'h00); byteOp = 1; end
			14'b00_0111_????????:
			begin
				s9 = {1'b0, src} + {1'b0, wr};
				hf = ({1'b0, src[3:0]} + {1'b0, wr[3:0]}) > 5'h0F;
				{cf, res} = s9;
				zf = (res == 8'h00);
				byteOp = 1;
			end
			14'b00_0010_????????:
			begin
				s9 = {1'b0, src} + {1'b0, ~wr} + 9'h001;
				hf = ({1'b0, src[3:0]} + {1'b0, ~wr[3:0]} + 5'h01) > 5'h0F;
				{cf, res} = s9;
				zf = (res == 8'h00);
				byteOp = 1;
			end
			14'b11_1001_????????: begin wr = wr & w[7:0]; zf = (wr == 8'h00); end
			14'b11_111?_????????:
			begin
				s9 = {1'b0, w[7:0]} + {1'b0, wr};
				hf = ({1'b0, w[3:0]} + {1'b0, wr[3:0]}) > 5'h0F;
				{cf, wr} = s9;
				zf = (wr == 8'h00);
			end
			WORD_RETURN, WORD_RETINT: begin pop = 1; two = 1; end
			WORD_CLRWDOG: begin wclr = 1; pclr = prescToWdog; toF = 1; pdF = 1; end
			WORD_STANDBY: begin wclr = 1; pclr = prescToWdog; sreq = 1; toF = 1; pdF = 0; end
			default: ;
		endcase
		if (byteOp && w[DEST_BIT])
		begin
			wrF = 1;
			fmem[w[6:0]] = res;
			pclr = (w[6:0] == ADDR_TIMER0_COUNT) && !prescToWdog;
		end
		else if (byteOp)
			wr = res;
		expQ.push_back('{{wrF, wrF ? {w[6:0], res} : 15'h0, wr, cf, hf, zf, wclr, pclr, sreq, pop, push, pcl, tgt,
			toF, pdF, 1'b0}, two, cyc + 1});
		if (two)
		begin
			@(negedge clk);
			insnValid = 1'b0;
			for (k = 0; k < 4 && idleCycle_ff !== 1'b1; k++)
				@(negedge clk);
			`CHK(idleCycle_ff, 1'b1)
		end
	endtask : issue

	// ****************************************
	// Output watcher
	// ****************************************
	always @(negedge clk)
	begin
		if (expQ.size() > 0 && expQ[0].due == cyc)
		begin
			`CHK({fileWrEn_ff, fileWrEn_ff ? {fileAddr_ff, fileWrData_ff} : 15'h0, wreg_ff, carry_ff, halfByteCarry_ff, zero_ff, watchdogClear_ff, prescClear_ff, standbyReq_ff, stackPop_ff, stackPush_ff, pcLoad_ff, pcLoad_ff ? pcTarget_ff : 11'h0, watchdogExpiryFlag_ff, standbyEnteredFlag_ff, expQ[0].two ? 1'b0 : idleCycle_ff}, expQ[0].v)
			void'(expQ.pop_front());
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{rstn, insnValid, prescToWdog, insnWord, portPins, errors, total_checks, cyc} = '0;
		void'($urandom(32'h0bad5bfe));
		for (int i = 0; i < 128; i++)
		begin
			fmem[i] = 8'($urandom);
			u_file.mem[i] = fmem[i];
		end
		do_reset();
		for (int i = 0; i < 400; i++)
		begin
			if (i == 200)
			begin
				issue(14'h3A5A);
				@(negedge clk);
				insnValid = 1'b0;
				@(negedge clk);
				expQ.delete();
				do_reset();
			end
			issue(tmpl[i % 24] | (14'($urandom) & msk[i % 24]));
		end
		@(negedge clk);
		insnValid = 1'b0;
		repeat (3) @(negedge clk);
		`CHK(expQ.size(), 0)
		print_verdict();
	end

	initial
	begin
		#1000000;
		errors++;
		print_verdict();
	end
endmodule : tb_midrange_14bit_instruction_decode
`default_nettype wire
